// ==== design/vectored_interrupt_priority_unit.sv ====
// vectored interrupt priority unit: flags, enables, levels, arbitration, vector fetch
// assumes request inputs are single-cycle or level pulses synchronous to mclk
// Behaviour
// - all requests merged into one cpu request
// - seven software levels per user source
// - each source owns its own vector slot
// - fixed entry and return cycle counts
// - primary table starts at word four
// - 126 slots: eight traps, 118 sources
// - handler address read from source slot
// - lower vector wins on equal level
// - reset clears registers, pc goes zero
// - trap slots consecutive, alternate plus 0x100
// - source bits follow vector order
// - write-done source uses vector fifteen
// - control bit selects alternate table
// - sources set flags, software clears them
// - disabled source raises no request
// - winner vector and level latched readable
//
// Local design decisions: the register offsets and the APB register port.
module vectored_interrupt_priority_unit
  import vip_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire apb_req_t          apb_req,
  output apb_rsp_t               apb_rsp,
  input  wire logic [NUM_SRC-1:0] src_request,
  input  wire logic [NUM_TRAP-1:0] trap_request,
  input  wire logic              cpu_ack,
  input  wire logic              cpu_return,
  output logic                   cpu_irq,
  output logic [23:0]            handler_addr,
  output logic                   handler_valid,
  output logic [23:0]            program_counter,
  output logic                   resume_valid,
  output logic                   event_irq
);

  logic [NUM_SRC-1:0]   flag_r;
  logic [NUM_SRC-1:0]   en_r;
  logic [2:0]           prio_r [NUM_SRC];
  logic [23:0]          vec_mem [NUM_VEC];
  logic [NUM_TRAP-1:0]  trap_r;
  logic                 alt_sel_r;
  logic                 nest_dis_r;
  logic [3:0]           cpu_level_r;
  logic [3:0]           saved_level_r;
  winner_t              pend_r;
  winner_t              win;
  winner_t              taken_r;
  seq_state_t           state_r;
  logic [1:0]           cnt_r;
  logic [1:0]           evt_stat_r;
  logic [1:0]           evt_mask_r;
  logic [1:0]           evt_set;
  logic [11:0]          ofs;
  logic                 wr_en;
  logic                 rd_en;
  logic [31:0]          rdata;
  logic [3:0]           best_lvl;

  assign ofs   = apb_req.paddr[11:0];
  assign wr_en = clk_en & apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_en = clk_en & apb_req.psel & apb_req.penable & ~apb_req.pwrite;

  always_comb
  begin
    win      = '0;
    best_lvl = cpu_level_r;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (flag_r[i] && en_r[i] && prio_r[i] != 3'h0 && {1'b0, prio_r[i]} > best_lvl)
      begin
        best_lvl  = {1'b0, prio_r[i]};
        win.valid = 1'b1;
        win.vec   = 7'(i);
        win.level = {1'b0, prio_r[i]};
      end
    end
    for (int t = NUM_TRAP - 1; t >= 0; t--)
    begin
      if (trap_r[t])
      begin
        win.valid   = 1'b1;
        win.is_trap = 1'b1;
        win.vec     = 7'(t);
        win.level   = 4'h8 + 4'(t);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      pend_r <= '0;
    else if (clk_en)
      pend_r <= win;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      flag_r <= '0;
    else if (clk_en)
    begin
      for (int w = 0; w < IRQ_WORDS; w++)
      begin
        for (int b = 0; b < 16; b++)
        begin
          if (w * 16 + b < NUM_SRC)
          begin
            if (src_request[w * 16 + b])
              flag_r[w * 16 + b] <= 1'b1;
            else if (wr_en && ofs == OFS_FLAG_BASE + 12'(w * 4))
              flag_r[w * 16 + b] <= apb_req.pwdata[b];
          end
        end
      end
    end
  end

  // write-done at word 0 bit 15
  always_ff @(posedge mclk)
  begin
    if (reset)
      en_r <= '0;
    else if (wr_en)
    begin
      for (int w = 0; w < IRQ_WORDS; w++)
      begin
        for (int b = 0; b < 16; b++)
        begin
          if (w * 16 + b < NUM_SRC && ofs == OFS_EN_BASE + 12'(w * 4))
            en_r[w * 16 + b] <= apb_req.pwdata[b];
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_SRC; i++)
        prio_r[i] <= 3'h0;
    end
    else if (wr_en)
    begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
        if (ofs == OFS_PRIO_BASE + 12'((i / 4) * 4))
          prio_r[i] <= apb_req.pwdata[(i % 4) * 4 +: 3];
      end
    end
  end

  // one slot per vector; 126 of them
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int v = 0; v < NUM_VEC; v++)
        vec_mem[v] <= VEC_RST;
    end
    else if (wr_en)
    begin
      for (int v = 0; v < NUM_VEC; v++)
      begin
        if (ofs == OFS_VEC_BASE + 12'(v * 4))
          vec_mem[v] <= apb_req.pwdata[23:0];
      end
    end
  end

  // trap status: hardware set wins, write one clears
  always_ff @(posedge mclk)
  begin
    if (reset)
      trap_r <= '0;
    else if (clk_en)
    begin
      for (int t = 0; t < NUM_TRAP; t++)
      begin
        if (trap_request[t])
          trap_r[t] <= 1'b1;
        else if (wr_en && ofs == OFS_CTRL_ONE && apb_req.pwdata[t])
          trap_r[t] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      alt_sel_r  <= 1'b0;
      nest_dis_r <= 1'b0;
    end
    else if (wr_en && ofs == OFS_CTRL_TWO)
      alt_sel_r <= apb_req.pwdata[ALT_SEL_BIT];
    else if (wr_en && ofs == OFS_CTRL_ONE)
      nest_dis_r <= apb_req.pwdata[15];
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_r       <= ST_IDLE;
      cnt_r         <= 2'h0;
      taken_r       <= '0;
      cpu_level_r   <= CPU_LEVEL_RST;
      saved_level_r <= CPU_LEVEL_RST;
      handler_valid <= 1'b0;
      resume_valid  <= 1'b0;
      program_counter <= RESET_ADDR;
      handler_addr    <= RESET_ADDR;
    end
    else if (clk_en)
    begin
      handler_valid <= 1'b0;
      resume_valid  <= 1'b0;
      unique case (state_r)
        ST_IDLE:
        begin
          if (cpu_ack && pend_r.valid)
          begin
            taken_r       <= pend_r;
            saved_level_r <= cpu_level_r;
            cpu_level_r   <= pend_r.level;
            cnt_r         <= 2'(ENTRY_CYCLES - 1);
            state_r       <= ST_ENTRY;
          end
          else if (wr_en && ofs == OFS_CPU_LEVEL && !nest_dis_r)
            cpu_level_r <= {1'b0, apb_req.pwdata[2:0]};
        end
        ST_ENTRY:
        begin
          if (cnt_r == 2'h0)
          begin
            handler_addr    <= vec_mem[taken_r.is_trap ? taken_r.vec : taken_r.vec + 7'h08];
            program_counter <= slot_addr(taken_r.vec, taken_r.is_trap, alt_sel_r);
            handler_valid   <= 1'b1;
            state_r         <= ST_SERVE;
          end
          else
            cnt_r <= cnt_r - 2'h1;
        end
        ST_SERVE:
        begin
          if (cpu_return)
          begin
            cnt_r   <= 2'(RETURN_CYCLES - 1);
            state_r <= ST_RETURN;
          end
        end
        ST_RETURN:
        begin
          if (cnt_r == 2'h0)
          begin
            cpu_level_r  <= saved_level_r;
            resume_valid <= 1'b1;
            state_r      <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r - 2'h1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      cpu_irq <= 1'b0;
    else if (clk_en)
      cpu_irq <= win.valid && state_r == ST_IDLE;
  end

  assign evt_set = {resume_valid, handler_valid};

  // event status: set beats write-one clear
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      evt_stat_r <= 2'h0;
      evt_mask_r <= 2'h0;
      event_irq  <= 1'b0;
    end
    else if (clk_en)
    begin
      for (int e = 0; e < 2; e++)
      begin
        if (evt_set[e])
          evt_stat_r[e] <= 1'b1;
        else if (wr_en && ofs == OFS_EVT_STAT && apb_req.pwdata[e])
          evt_stat_r[e] <= 1'b0;
      end
      if (wr_en && ofs == OFS_EVT_MASK)
        evt_mask_r <= apb_req.pwdata[1:0];
      event_irq <= |(evt_stat_r & evt_mask_r);
    end
  end

  always_comb
  begin
    rdata = 32'h00000000;
    if (ofs == OFS_CTRL_ONE)
      rdata = {16'h0000, nest_dis_r, 7'h00, trap_r};
    else if (ofs == OFS_CTRL_TWO)
      rdata = {16'h0000, alt_sel_r, 15'h0000};
    else if (ofs == OFS_PENDING)
      rdata = {20'h00000, pend_r.level, 1'b0, pend_r.vec};
    else if (ofs == OFS_CPU_LEVEL)
      rdata = {28'h0000000, cpu_level_r};
    else if (ofs == OFS_EVT_STAT)
      rdata = {30'h00000000, evt_stat_r};
    else if (ofs == OFS_EVT_MASK)
      rdata = {30'h00000000, evt_mask_r};
    for (int w = 0; w < IRQ_WORDS; w++)
    begin
      for (int b = 0; b < 16; b++)
      begin
        if (w * 16 + b < NUM_SRC && ofs == OFS_FLAG_BASE + 12'(w * 4))
          rdata[b] = flag_r[w * 16 + b];
        if (w * 16 + b < NUM_SRC && ofs == OFS_EN_BASE + 12'(w * 4))
          rdata[b] = en_r[w * 16 + b];
      end
    end
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (ofs == OFS_PRIO_BASE + 12'((i / 4) * 4))
        rdata[(i % 4) * 4 +: 3] = prio_r[i];
    end
    for (int v = 0; v < NUM_VEC; v++)
    begin
      if (ofs == OFS_VEC_BASE + 12'(v * 4))
        rdata[23:0] = vec_mem[v];
    end
  end

  // single-cycle access phase, unmapped reads return zero
  always_ff @(posedge mclk)
  begin
    if (reset)
      apb_rsp <= '0;
    else if (clk_en)
    begin
      apb_rsp.pready  <= apb_req.psel & ~apb_req.penable;
      apb_rsp.pslverr <= 1'b0;
      if (apb_req.psel && !apb_req.penable)
        apb_rsp.prdata <= rdata;
    end
  end

endmodule : vectored_interrupt_priority_unit

// ==== design/vip_pkg.sv ====
// constants, types and register map of the vectored interrupt priority unit
// assumes a single mclk domain with synchronous active-high reset
package vip_pkg;

  localparam int unsigned NUM_SRC       = 118;
  localparam int unsigned NUM_TRAP      = 8;
  localparam int unsigned NUM_VEC       = 126;
  localparam int unsigned IRQ_WORDS     = 8;
  localparam int unsigned PRIO_WORDS    = 30;

  // program memory word addresses
  localparam logic [23:0] RESET_ADDR    = 24'h000000;
  localparam logic [23:0] PRIMARY_BASE  = 24'h000004;
  localparam logic [23:0] ALT_OFFSET    = 24'h000100;
  localparam logic [23:0] USER_BASE     = 24'h000014;

  // trap numbers
  localparam logic [2:0] TRAP_OSC_FAIL  = 3'h1;
  localparam logic [2:0] TRAP_ADDR_ERR  = 3'h2;
  localparam logic [2:0] TRAP_STACK_ERR = 3'h3;
  localparam logic [2:0] TRAP_MATH_ERR  = 3'h4;

  // user vectors named in the map
  localparam logic [6:0] VEC_EXT0       = 7'h00;
  localparam logic [6:0] VEC_CAPTURE1   = 7'h01;
  localparam logic [6:0] VEC_COMPARE1   = 7'h02;
  localparam logic [6:0] VEC_TIMER1     = 7'h03;
  localparam logic [6:0] VEC_TIMER2     = 7'h07;
  localparam logic [6:0] VEC_TIMER3     = 7'h08;
  localparam logic [6:0] VEC_NVM_DONE   = 7'h0f;

  // apb byte offsets
  localparam logic [11:0] OFS_CTRL_ONE  = 12'h000;
  localparam logic [11:0] OFS_CTRL_TWO  = 12'h004;
  localparam logic [11:0] OFS_PENDING   = 12'h008;
  localparam logic [11:0] OFS_CPU_LEVEL = 12'h00c;
  localparam logic [11:0] OFS_EVT_STAT  = 12'h010;
  localparam logic [11:0] OFS_EVT_MASK  = 12'h014;
  localparam logic [11:0] OFS_FLAG_BASE = 12'h040;
  localparam logic [11:0] OFS_EN_BASE   = 12'h080;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h0c0;
  localparam logic [11:0] OFS_VEC_BASE  = 12'h200;

  // field positions
  localparam int unsigned ALT_SEL_BIT   = 15;
  localparam int unsigned NVM_FLAG_BIT  = 15;
  localparam int unsigned PEND_LVL_LSB  = 8;

  // reset values
  localparam logic [3:0]  CPU_LEVEL_RST = 4'h0;
  localparam logic [23:0] VEC_RST       = 24'h000000;

  // interrupt/trap entry and return take these fixed cycle counts
  localparam int unsigned ENTRY_CYCLES  = 3;
  localparam int unsigned RETURN_CYCLES = 2;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_ENTRY  = 2'b01,
    ST_SERVE  = 2'b10,
    ST_RETURN = 2'b11
  } seq_state_t;

  typedef struct packed
  {
    logic       valid;
    logic       is_trap;
    logic [6:0] vec;
    logic [3:0] level;
  } winner_t;

  typedef struct packed
  {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed
  {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // program word address of a table slot
  function automatic logic [23:0] slot_addr(input logic [6:0] vec, input logic trap,
                                            input logic alt);
    logic [23:0] base;
    base = trap ? PRIMARY_BASE : USER_BASE;
    if (alt)
    begin
      base = base + ALT_OFFSET;
    end
    return base + {16'h0000, vec, 1'b0};
  endfunction : slot_addr

endpackage : vip_pkg

// ==== dv/vip_sva.sv ====
// checker: entry and return timing, pc updates, bus answer
// assumes it is bound into the unit and sees only its ports
module vip_sva
  import vip_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire apb_req_t    apb_req,
  input wire apb_rsp_t    apb_rsp,
  input wire logic        cpu_ack,
  input wire logic        cpu_return,
  input wire logic        cpu_irq,
  input wire logic        handler_valid,
  input wire logic [23:0] program_counter,
  input wire logic        resume_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_take;
    cpu_ack && cpu_irq;
  endsequence
  // entry pulse is launched three edges after the ack edge, so it is sampled on the fourth
  sequence s_enter;
    ##4 handler_valid;
  endsequence

  a_entry_fixed:
    assert property (s_take |-> s_enter)
    else $error("entry late");
  a_entry_cause:
    assert property (handler_valid |-> $past(cpu_ack, 4))
    else $error("entry without ack");
  a_return_fixed:
    assert property (cpu_return |-> ##3 resume_valid)
    else $error("return late");
  a_entry_pulse:
    assert property (handler_valid |=> !handler_valid [*3])
    else $error("entry pulse long");
  a_pc_holds:
    assert property (!handler_valid |-> $stable(program_counter))
    else $error("pc moved");
  a_pc_in_table:
    assert property (handler_valid |-> program_counter >= PRIMARY_BASE
      && program_counter < 24'h000200 && !program_counter[0])
    else $error("pc off table");
  a_bus_ready:
    assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("bus answer late");
  a_reset_clears:
    assert property (disable iff (1'b0) reset |=> program_counter == RESET_ADDR && !cpu_irq)
    else $error("reset left state");
endmodule : vip_sva

bind vectored_interrupt_priority_unit vip_sva vip_sva_inst
(
  .mclk, .reset, .apb_req, .apb_rsp, .cpu_ack, .cpu_return, .cpu_irq,
  .handler_valid, .program_counter, .resume_valid
);

// ==== dv/cpu_core_model.sv ====
// cpu stand-in: takes a presented request, serves a while, returns
// assumes entry and resume are one-cycle pulses from the unit
module cpu_core_model
#(
  parameter int HOLD = 12
)
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic go,
  input  wire logic cpu_irq,
  input  wire logic handler_valid,
  input  wire logic resume_valid,
  output logic      cpu_ack,
  output logic      cpu_return
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  int   cnt;

  always_ff @(posedge mclk)
  begin
    cpu_ack    <= !reset && !busy && go && cpu_irq;
    cpu_return <= !reset && busy && cnt == HOLD;
    if (reset)
    begin
      busy <= 1'b0;
      cnt  <= 0;
    end
    else if (!busy)
    begin
      busy <= go && cpu_irq;
      cnt  <= 0;
    end
    else
    begin
      if (cnt == HOLD)
        cnt <= 0;
      else if (handler_valid)
        cnt <= 1;
      else if (cnt > 0)
        cnt <= cnt + 1;
      // stale request is low until resume, so no double ack
      if (resume_valid)
        busy <= 1'b0;
    end
  end
endmodule : cpu_core_model

// ==== dv/vectored_interrupt_priority_unit_bench.sv ====
// bench: apb register tasks, request pulses, cpu stand-in serving entries
// assumes the checker is bound in; one 50 MHz clock
module vectored_interrupt_priority_unit_bench
  import vip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic               go = 1'b0;
  logic               run = 1'b1;
  logic               slv;
  apb_req_t           req = '0;
  apb_rsp_t           rsp;
  logic [NUM_SRC-1:0] src = '0;
  logic [7:0]         trap = '0;
  logic               ack, ret, irq, hv, rv, eirq;
  logic [23:0]        haddr, pc;
  logic [31:0]        d;
  int                 errors = 0;
  int                 n_compared = 0;
  int                 cyc = 0;

  always #10 mclk = ~mclk;

  vectored_interrupt_priority_unit vectored_interrupt_priority_unit_inst
  (
    .mclk(mclk), .reset(reset), .clk_en(run), .apb_req(req), .apb_rsp(rsp),
    .src_request(src), .trap_request(trap), .cpu_ack(ack), .cpu_return(ret),
    .cpu_irq(irq), .handler_addr(haddr), .handler_valid(hv), .program_counter(pc),
    .resume_valid(rv), .event_irq(eirq)
  );

  cpu_core_model cpu_core_model_inst
  (
    .mclk(mclk), .reset(reset), .go(go), .cpu_irq(irq), .handler_valid(hv),
    .resume_valid(rv), .cpu_ack(ack), .cpu_return(ret)
  );

  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge; answer taken at that edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    req <= '{{20'h00000, a}, 1'b1, 1'b0, w, v};
    @(posedge mclk);
    req.penable <= 1'b1;
    @(posedge mclk);
    while (rsp.pready !== 1'b1)
      @(posedge mclk);
    d   = rsp.prdata;
    slv = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : bus

  task automatic fire(input logic [NUM_SRC-1:0] s, input logic [7:0] t);
    @(posedge mclk);
    src <= s;
    trap <= t;
    @(posedge mclk);
    src <= '0;
    trap <= '0;
    repeat (2) @(posedge mclk);
  endtask : fire

  task automatic ent(input logic [23:0] e);
    @(negedge mclk);
    while (hv !== 1'b1)
      @(negedge mclk);
    chk("pc", {8'h00, e}, {8'h00, pc});
  endtask : ent

  initial
  begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    bus(0, OFS_PENDING, 0);
    chk("pend", 0, d);
    chk("pc", 0, {8'h00, pc});
    bus(0, 12'h020, 0);
    chk("hole", 0, d);
    chk("slverr", 0, {31'h0, slv});
    bus(1, OFS_VEC_BASE + 12'h02c, 32'h00001234);
    bus(1, OFS_EN_BASE, 32'h00008088);
    bus(1, OFS_PRIO_BASE, 32'h00002000);
    bus(1, OFS_PRIO_BASE + 12'h004, 32'h00002000);
    fire(118'h8088, 8'h00);
    bus(0, OFS_PENDING, 0);
    chk("pend", 32'h0203, d);
    bus(1, OFS_PRIO_BASE + 12'h00c, 32'h00005000);
    bus(0, OFS_PENDING, 0);
    chk("pend", 32'h050f, d);
    bus(1, OFS_EN_BASE, 32'h00000088);
    bus(0, OFS_PENDING, 0);
    chk("pend", 32'h0203, d);
    bus(0, OFS_FLAG_BASE, 0);
    chk("flags", 32'h8088, d);
    // a frozen clock enable must not let a request set its flag
    run <= 1'b0;
    fire(118'h1, 8'h00);
    run <= 1'b1;
    bus(0, OFS_FLAG_BASE, 0);
    chk("frozen flags", 32'h8088, d);
    go <= 1'b1;
    ent(USER_BASE + 24'h000006);
    chk("haddr", 32'h1234, {8'h00, haddr});
    bus(1, OFS_FLAG_BASE, 32'h00008080);
    ent(USER_BASE + 24'h00000e);
    bus(1, OFS_FLAG_BASE, 32'h00008000);
    bus(1, OFS_CTRL_TWO, 32'h00008000);
    bus(1, OFS_EN_BASE, 32'h00008000);
    ent(USER_BASE + ALT_OFFSET + 24'h00001e);
    bus(1, OFS_FLAG_BASE, 0);
    fire(118'h8000, 8'h04);
    ent(PRIMARY_BASE + ALT_OFFSET + 24'h000004);
    bus(0, OFS_CTRL_ONE, 0);
    chk("trap", 32'h4, d);
    bus(1, OFS_CTRL_ONE, 32'h4);
    ent(USER_BASE + ALT_OFFSET + 24'h00001e);
    bus(1, OFS_FLAG_BASE, 0);
    repeat (20) @(negedge mclk);
    chk("eirq", 0, {31'h0, eirq});
    bus(0, OFS_EVT_STAT, 0);
    chk("evt", 3, d);
    bus(1, OFS_EVT_MASK, 1);
    repeat (3) @(negedge mclk);
    chk("eirq", 1, {31'h0, eirq});
    bus(1, OFS_EVT_STAT, 3);
    repeat (3) @(negedge mclk);
    chk("eirq", 0, {31'h0, eirq});
    // nest disable locks the cpu level against software writes
    bus(1, OFS_CTRL_ONE, 32'h00008000);
    bus(1, OFS_CPU_LEVEL, 6);
    bus(0, OFS_CPU_LEVEL, 0);
    chk("level", 0, d);
    bus(1, OFS_CTRL_ONE, 0);
    // equal level must stay blocked, one lower lets it through
    bus(1, OFS_CPU_LEVEL, 5);
    fire(118'h8000, 8'h00);
    repeat (3) @(negedge mclk);
    chk("irq", 0, {31'h0, irq});
    bus(1, OFS_CPU_LEVEL, 4);
    ent(USER_BASE + ALT_OFFSET + 24'h00001e);
    repeat (20) @(posedge mclk);
    close_out();
  end
endmodule : vectored_interrupt_priority_unit_bench
